// file: bench/swc_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module swc_core_model (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset
    input wire logic resume, // wake without reset
    input wire logic core_clk_en, // core clock gate
    output logic instr_done // prefetched op retired
);
    // ----------------------------------------
    // prefetched instruction
    // ----------------------------------------
    logic [1:0] cnt; // cycles left on the op
    // the op only advances while the core clock runs
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= 2'h0;
            instr_done <= 1'b0;
        end
        else
        begin
            instr_done <= (cnt == 2'h1) && core_clk_en;
            if (resume)
                cnt <= 2'h2;
            else if ((cnt != 2'h0) && core_clk_en)
                cnt <= cnt - 2'h1;
        end
    end
endmodule // swc_core_model
`default_nettype wire

// file: bench/swc_sleep_wake_controller_bench.sv
`timescale 1ns/1ns
`default_nettype none
module swc_sleep_wake_controller_bench;
    // ----------------------------------------
    // stimulus, dut and core model
    // ----------------------------------------
    typedef struct packed {
        logic wdt; // wake by watchdog, else irq
        logic en; // enable of that source
        logic global_interrupt_enable; // global enable
        logic [1:0] t1; // timer clock select
        logic adc; // adc clock select
        logic [3:0] exp; // resume, vector, wdt clear, reset
    } swc_row_t;
    swc_row_t rows [5] = '{{6'h11, 4'hA}, {6'h1A, 4'hE}, {6'h0D, 4'h0},
        {6'h36, 4'hA}, {6'h23, 4'h0}};
    logic clk = 1'b0, rst_n = 1'b0, slp = 1'b0, wen = 1'b0, global_interrupt_enable = 1'b0;
    logic adc_sel = 1'b0, idone; // adc select, core done
    logic [1:0] t1_sel = 2'h0; // timer clock select
    logic [7:0] irq = 8'h00, ien = 8'h00; // flags and enables
    swc_pkg::swc_wake_t wake = '0; // reset and watchdog events
    logic cke, pd, to, wclr, drst, vec, res, hold, t1, adc, lf, asl;
    logic [3:0] seen = 4'h0; // pulses seen since last clear
    int n_fail = 0, n_checks = 0;
    swc_sleep_wake_controller uut (.MCLK(clk), .RST_N(rst_n), .SLEEP_EXEC(slp),
        .WDT_SLEEP_EN(wen), .WAKE_SRC(wake), .IRQ_FLAG(irq), .IRQ_EN(ien),
        .GLOBAL_INTERRUPT_ENABLE(global_interrupt_enable), .T1_CLK_SEL(t1_sel), .ADC_CLK_SEL(adc_sel),
        .INSTR_DONE(idone), .CORE_CLK_EN(cke), .POWER_DOWN_FLAG(pd),
        .TIME_OUT_FLAG(to), .WDT_CLEAR(wclr), .DEV_RESET(drst), .ISR_VECTOR(vec),
        .RESUME(res), .IO_HOLD(hold), .T1_RUN(t1), .ADC_RUN(adc), .LF_OSC_RUN(lf),
        .ASLEEP(asl));
    swc_core_model core (.clk(clk), .rst_n(rst_n), .resume(res),
        .core_clk_en(cke), .instr_done(idone));
    always #5 clk = ~clk;
    // collect one-cycle pulses at the falling edge, where outputs are settled
    always @(negedge clk)
        seen <= seen | {res, vec, wclr, drst};
    // ----------------------------------------
    // helper tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [3:0] got, input logic [3:0] want);
        n_checks++;
        if (got !== want)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, want, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // reset is also the way out of a sleep that nothing woke
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        chk("reset", {cke, pd, to, asl}, 4'hE);
    endtask
    task automatic sleep_in();
        slp = 1'b1;
        @(posedge clk);
        #1 slp = 1'b0;
        chk("asleep", asl, 1'b1);
        chk("clk_en", cke, 1'b0);
        chk("wdt_clr", wclr, 1'b1);
        chk("pd_to", {pd, to}, 2'h1);
        chk("io_hold", hold, 1'b1);
        chk("lf_run", lf, 1'b1);
        // let the entry clear pulse pass before collecting wake pulses
        @(posedge clk);
        #1 seen = 4'h0;
    endtask
    // ----------------------------------------
    // table rows, then reset wakes
    // ----------------------------------------
    initial
    begin
        for (int i = 0; i < 5; i++)
        begin
            do_reset();
            {t1_sel, adc_sel, global_interrupt_enable} = {rows[i].t1, rows[i].adc, rows[i].global_interrupt_enable};
            sleep_in();
            chk("t1_run", t1, rows[i].t1 != swc_pkg::SWC_T1_SYS);
            chk("adc_run", adc, rows[i].adc == swc_pkg::SWC_ADC_RC);
            irq = 8'h11; // bit 0 has no enable and must not wake
            ien = (rows[i].en && !rows[i].wdt) ? 8'h10 : 8'h00;
            wen = rows[i].en;
            wake.watchdog = rows[i].wdt;
            repeat (12) @(posedge clk);
            #1 chk("wake", seen, rows[i].exp);
            chk("still_asleep", asl, !rows[i].exp[3]);
            {irq, ien, wen, wake} = '0;
            $display("row %0d done", i);
        end
        for (int k = 0; k < 3; k++)
        begin
            do_reset();
            sleep_in();
            wake = swc_pkg::swc_wake_t'(4'h8 >> k);
            @(posedge clk);
            #1 wake = '0;
            repeat (3) @(posedge clk);
            #1 chk("reset_wake", {seen[3], seen[0]}, 2'h1);
            $display("reset wake %0d done", k);
        end
        end_of_test();
    end
    // cut a hang short
    initial
    begin
        #20000;
        n_fail++;
        end_of_test();
    end
endmodule // swc_sleep_wake_controller_bench
`default_nettype wire

// file: core/swc_pkg.sv
// How it works
// - sleep instruction enters power-down
// - watchdog cleared on entry, runs if enabled
// - power-down flag cleared on entry
// - time-out flag set on entry
// - core clock stopped while asleep
// - low-frequency oscillator keeps running in sleep
// - secondary timer runs on sleep-capable clocks
// - adc keeps running on dedicated rc
// - io pins hold their drive state
// - other resets unaffected by sleep
// - listed events wake the device
// - reset wakes reset, others resume
// - next instruction prefetched during sleep
// - wake needs individual enable, ignores global
// - global off: resume after sleep
// - global on: next instruction, then vector
// - watchdog cleared on every non-reset wake
`default_nettype none
package swc_pkg;

    // ----------------------------------------
    // states and widths
    // ----------------------------------------
    typedef enum logic [2:0] {
        SWC_RUN   = 3'b000, // core running
        SWC_SLEEP = 3'b001, // clock gated
        SWC_WAKE  = 3'b010, // clock restarting
        SWC_EXEC  = 3'b011, // prefetched instruction running
        SWC_VECT  = 3'b100  // branch to service routine
    } swc_state_t;

    localparam int SWC_IRQ_W = 8; // number of interrupt sources

    // secondary_timer clock source codes
    localparam logic [1:0] SWC_T1_SYS = 2'h0; // instruction clock, stops in sleep
    localparam logic [1:0] SWC_T1_LF = 2'h1; // low-frequency oscillator
    localparam logic [1:0] SWC_T1_PIN = 2'h2; // external clock pin
    localparam logic [1:0] SWC_T1_XTAL = 2'h3; // own crystal oscillator

    localparam logic SWC_ADC_RC = 1'b1; // adc clock select: dedicated rc

    // wake sources, packed
    typedef struct packed {
        logic ext_reset;  // external reset pin, enabled
        logic brownout;   // brown-out reset, enabled
        logic por;        // power-on reset
        logic watchdog;   // watchdog timeout, enabled
    } swc_wake_t;

    // whole module state
    typedef struct packed {
        swc_state_t st;         // sequencer state
        logic core_clk_en;      // core clock gate
        logic power_down_flag;  // status bit, low after sleep
        logic time_out_flag;    // status bit
        logic wdt_clear;        // watchdog clear pulse
        logic dev_reset;        // full device reset request
        logic vector;           // vector to isr pulse
        logic resume;           // resume pulse
        logic io_hold;          // pin latch freeze
        logic t1_run;           // secondary timer enable
        logic adc_run;          // adc enable
        logic lf_run;           // low-frequency osc enable
        logic asleep;           // sleep state flag, drives the pin
    } swc_regs_t;

endpackage
`default_nettype wire

// file: core/swc_sleep_wake_controller.sv
`timescale 1ns/1ns
`default_nettype none
module swc_sleep_wake_controller #(
    parameter int IRQ_W = swc_pkg::SWC_IRQ_W // interrupt source count
) (
    input wire logic MCLK, // 100 mhz clock
    input wire logic RST_N, // async reset, active low
    input wire logic SLEEP_EXEC, // core executes sleep instruction
    input wire logic WDT_SLEEP_EN, // watchdog runs during sleep
    input wire swc_pkg::swc_wake_t WAKE_SRC, // reset and watchdog wake events
    input wire logic [IRQ_W-1:0] IRQ_FLAG, // interrupt flags
    input wire logic [IRQ_W-1:0] IRQ_EN, // individual enables
    input wire logic GLOBAL_INTERRUPT_ENABLE, // global enable
    input wire logic [1:0] T1_CLK_SEL, // secondary timer clock source
    input wire logic ADC_CLK_SEL, // adc clock source
    input wire logic INSTR_DONE, // core finished one instruction
    output logic CORE_CLK_EN, // core clock gate
    output logic POWER_DOWN_FLAG, // status bit
    output logic TIME_OUT_FLAG, // status bit
    output logic WDT_CLEAR, // watchdog clear pulse
    output logic DEV_RESET, // full device reset request
    output logic ISR_VECTOR, // branch to interrupt routine
    output logic RESUME, // non-reset wake pulse
    output logic IO_HOLD, // io pin state frozen
    output logic T1_RUN, // secondary timer enabled
    output logic ADC_RUN, // adc enabled
    output logic LF_OSC_RUN, // low-frequency oscillator enabled
    output logic ASLEEP // sleep state
);

    // scope: the sequencer drives gate, clear, hold, run and flag levels and its pulses; the
    // watchdog counter, timers, adc and oscillators sit in their own
    // blocks and simply follow the run levels given here
    // trade-off: every output comes from a flop, so each answer shows at
    // the pins just after the edge that took its request, a cycle after it was raised
    // limitation: the status flags only move on sleep entry and RST_N here; the
    // clear-watchdog operation and reset causes update them elsewhere
    // hazard: a watchdog line stuck high is ignored unless it may run asleep

    // ----------------------------------------
    // state
    // ----------------------------------------
    swc_pkg::swc_regs_t r; // registered state
    swc_pkg::swc_regs_t next_r; // next state
    logic irq_wake; // enabled interrupt pending
    logic rst_wake; // reset-class wake
    logic t1_sleep_ok; // timer clock survives sleep
    logic soft_wake; // non-reset wake request while asleep

    // ----------------------------------------
    // wake decode
    // ----------------------------------------
    // non-reset wake: an enabled interrupt, or a watchdog timeout that
    // may run in sleep; shared by the sequencer and its checks so both
    // always agree on what counts as a wake
    function automatic logic wake_event(
        input logic wdt_timeout, // watchdog timeout seen
        input logic wdt_in_sleep, // watchdog enabled for sleep
        input logic irq_pending // enabled interrupt flagged
    );
        return (wdt_timeout && wdt_in_sleep) || irq_pending;
    endfunction

    // wake needs individual enable only; global enable ignored
    assign irq_wake = |(IRQ_FLAG & IRQ_EN);
    assign rst_wake = WAKE_SRC.ext_reset | WAKE_SRC.brownout | WAKE_SRC.por;
    assign t1_sleep_ok = (T1_CLK_SEL != swc_pkg::SWC_T1_SYS);
    assign soft_wake = wake_event(WAKE_SRC.watchdog, WDT_SLEEP_EN, irq_wake);

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    // one copy of the state is built here and registered below; pulses
    // default low so each lasts a single cycle, levels hold by default
    // limitation: a reset source that stays high repeats the reset
    // pulse every cycle, the reset controller is expected to stretch it
    always_comb
    begin
        next_r = r;
        next_r.wdt_clear = 1'b0;
        next_r.dev_reset = 1'b0;
        next_r.vector = 1'b0;
        next_r.resume = 1'b0;
        next_r.lf_run = 1'b1;
        // reset sources act in every state, sleep does not mask them
        if (rst_wake)
        begin
            next_r.dev_reset = 1'b1;
            next_r.st = swc_pkg::SWC_RUN;
            next_r.core_clk_en = 1'b1;
            next_r.io_hold = 1'b0;
            next_r.t1_run = 1'b1;
            next_r.adc_run = 1'b1;
        end
        else
        begin
            case (r.st)
                swc_pkg::SWC_RUN:
                begin
                    // sleep is only honoured here; elsewhere the core is
                    // not fetching, so a request would be stale
                    if (SLEEP_EXEC)
                    begin
                        next_r.st = swc_pkg::SWC_SLEEP;
                        next_r.wdt_clear = 1'b1;
                        next_r.power_down_flag = 1'b0;
                        next_r.time_out_flag = 1'b1;
                        next_r.core_clk_en = 1'b0;
                        next_r.io_hold = 1'b1;
                        next_r.t1_run = t1_sleep_ok;
                        next_r.adc_run = (ADC_CLK_SEL == swc_pkg::SWC_ADC_RC);
                    end
                end
                swc_pkg::SWC_SLEEP:
                begin
                    // watchdog timeout only counts while enabled in sleep
                    // same decode as the stay-asleep check below
                    if (soft_wake)
                    begin
                        next_r.st = swc_pkg::SWC_WAKE;
                        next_r.wdt_clear = 1'b1;
                        next_r.core_clk_en = 1'b1;
                        next_r.io_hold = 1'b0;
                        next_r.t1_run = 1'b1;
                        next_r.adc_run = 1'b1;
                    end
                end
                swc_pkg::SWC_WAKE:
                begin
                    // clock now running, prefetched instruction goes first
                    next_r.st = swc_pkg::SWC_EXEC;
                    next_r.resume = 1'b1;
                end
                swc_pkg::SWC_EXEC:
                begin
                    // vector only if the interrupt is still pending when the
                    // prefetched op retires; a cleared flag gives a plain resume
                    if (INSTR_DONE)
                    begin
                        if (GLOBAL_INTERRUPT_ENABLE && irq_wake)
                        begin
                            next_r.st = swc_pkg::SWC_VECT;
                            next_r.vector = 1'b1;
                        end
                        else
                        begin
                            next_r.st = swc_pkg::SWC_RUN;
                        end
                    end
                end
                swc_pkg::SWC_VECT:
                begin
                    // one cycle for the core to take the vector pulse
                    next_r.st = swc_pkg::SWC_RUN; // back to normal
                end
                default:
                begin
                    // unused codes fall back to running, clock stays as is
                    next_r.st = swc_pkg::SWC_RUN; // recover
                end
            endcase
        end
        // flag decoded from the next state so the pin comes from a flop
        next_r.asleep = (next_r.st == swc_pkg::SWC_SLEEP);
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    // reset loads constants only; run levels come up high so nothing
    // downstream sees a false sleep while reset is released
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            r.st <= swc_pkg::SWC_RUN;
            r.core_clk_en <= 1'b1;
            r.power_down_flag <= 1'b1;
            r.time_out_flag <= 1'b1;
            r.wdt_clear <= 1'b0;
            r.dev_reset <= 1'b0;
            r.vector <= 1'b0;
            r.resume <= 1'b0;
            r.io_hold <= 1'b0;
            r.t1_run <= 1'b1;
            r.adc_run <= 1'b1;
            r.lf_run <= 1'b1;
            r.asleep <= 1'b0;
        end
        else
        begin
            r <= next_r;
        end
    end

    // outputs straight from flip-flops
    // no decode sits between a flop and a pin, so no glitch reaches
    // the clock gate or the pin latches
    assign CORE_CLK_EN = r.core_clk_en;
    assign POWER_DOWN_FLAG = r.power_down_flag;
    assign TIME_OUT_FLAG = r.time_out_flag;
    assign WDT_CLEAR = r.wdt_clear;
    assign DEV_RESET = r.dev_reset;
    assign ISR_VECTOR = r.vector;
    assign RESUME = r.resume;
    assign IO_HOLD = r.io_hold;
    assign T1_RUN = r.t1_run;
    assign ADC_RUN = r.adc_run;
    assign LF_OSC_RUN = r.lf_run;
    assign ASLEEP = r.asleep;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_ENTER: assert property (@(posedge MCLK) disable iff (!RST_N)
        (r.st == swc_pkg::SWC_RUN && SLEEP_EXEC && !rst_wake) |=> ASLEEP)
        else $error("sleep not entered");
    AST_WDT_ENTRY: assert property (@(posedge MCLK) disable iff (!RST_N)
        (!ASLEEP ##1 ASLEEP) |-> WDT_CLEAR)
        else $error("watchdog not cleared on entry");
    AST_PD: assert property (@(posedge MCLK) disable iff (!RST_N)
        (!ASLEEP ##1 ASLEEP) |-> !POWER_DOWN_FLAG)
        else $error("power-down flag not cleared");
    AST_TO: assert property (@(posedge MCLK) disable iff (!RST_N)
        (!ASLEEP ##1 ASLEEP) |-> TIME_OUT_FLAG)
        else $error("time-out flag not set");
    AST_CLK: assert property (@(posedge MCLK) disable iff (!RST_N)
        ASLEEP |-> !CORE_CLK_EN)
        else $error("core clock running in sleep");
    AST_IO: assert property (@(posedge MCLK) disable iff (!RST_N)
        ASLEEP |-> IO_HOLD)
        else $error("io not held in sleep");
    AST_IRQ_WAKE: assert property (@(posedge MCLK) disable iff (!RST_N)
        (ASLEEP && irq_wake && !rst_wake) |=> (CORE_CLK_EN && WDT_CLEAR ##1 RESUME))
        else $error("enabled interrupt did not wake");
    AST_RESET_WAKE: assert property (@(posedge MCLK) disable iff (!RST_N)
        (ASLEEP && rst_wake) |=> (DEV_RESET && !ASLEEP))
        else $error("reset wake did not reset");
    AST_NOVEC: assert property (@(posedge MCLK) disable iff (!RST_N)
        (r.st == swc_pkg::SWC_EXEC && INSTR_DONE && !GLOBAL_INTERRUPT_ENABLE
         && !rst_wake) |=> !ISR_VECTOR)
        else $error("vectored with global disabled");
    AST_VEC: assert property (@(posedge MCLK) disable iff (!RST_N)
        (r.st == swc_pkg::SWC_EXEC && INSTR_DONE && GLOBAL_INTERRUPT_ENABLE
         && irq_wake && !rst_wake) |=> ISR_VECTOR)
        else $error("no vector with global enabled");

    // ----------------------------------------
    // wake and hold checks
    // ----------------------------------------
    // these cover the levels and pulses around a wake, including the
    // cases where nothing may change

    // every non-reset wake clears the watchdog
    AST_WDT_WAKE: assert property (@(posedge MCLK) disable iff (!RST_N)
        (ASLEEP ##1 (!ASLEEP && !DEV_RESET)) |-> WDT_CLEAR)
        else $error("watchdog not cleared on wake");

    // clock back on as soon as sleep is left
    AST_CLK_WAKE: assert property (@(posedge MCLK) disable iff (!RST_N)
        (ASLEEP ##1 (!ASLEEP && !DEV_RESET)) |-> CORE_CLK_EN)
        else $error("core clock off after wake");

    // resume follows the restart step
    AST_RESUME: assert property (@(posedge MCLK) disable iff (!RST_N)
        (r.st == swc_pkg::SWC_WAKE && !rst_wake) |=> RESUME)
        else $error("no resume after restart");

    // timer run level follows its clock source on entry
    AST_T1_ENTRY: assert property (@(posedge MCLK) disable iff (!RST_N)
        (r.st == swc_pkg::SWC_RUN && SLEEP_EXEC && !rst_wake) |=> (T1_RUN == $past(t1_sleep_ok)))
        else $error("timer run level wrong in sleep");

    // adc run level follows its clock source on entry
    AST_ADC_ENTRY: assert property (@(posedge MCLK) disable iff (!RST_N)
        (r.st == swc_pkg::SWC_RUN && SLEEP_EXEC && !rst_wake)
        |=> (ADC_RUN == $past(ADC_CLK_SEL == swc_pkg::SWC_ADC_RC)))
        else $error("adc run level wrong in sleep");

    // low-frequency oscillator never stopped by sleep
    AST_LF: assert property (@(posedge MCLK) disable iff (!RST_N)
        ASLEEP |-> LF_OSC_RUN)
        else $error("low-frequency oscillator stopped");

    // without an allowed wake the part stays asleep
    AST_STAY: assert property (@(posedge MCLK) disable iff (!RST_N)
        (ASLEEP && !soft_wake && !rst_wake) |=> ASLEEP)
        else $error("woke without an enabled source");

    // pins released when sleep is left
    AST_IO_RELEASE: assert property (@(posedge MCLK) disable iff (!RST_N)
        (ASLEEP ##1 !ASLEEP) |-> !IO_HOLD)
        else $error("io still held after wake");

    // reset sources act in every state
    AST_RESET_ANY: assert property (@(posedge MCLK) disable iff (!RST_N)
        rst_wake |=> DEV_RESET)
        else $error("reset source ignored");

    // resume lasts one cycle
    AST_RESUME_PULSE: assert property (@(posedge MCLK) disable iff (!RST_N)
        RESUME |=> !RESUME)
        else $error("resume longer than one cycle");

    // a reset wake never resumes
    AST_NO_RESUME_RESET: assert property (@(posedge MCLK) disable iff (!RST_N)
        DEV_RESET |-> !RESUME)
        else $error("resume during reset");

    // sleep request outside running is dropped
    AST_SLEEP_REFUSED: assert property (@(posedge MCLK) disable iff (!RST_N)
        (r.st != swc_pkg::SWC_RUN && !ASLEEP && SLEEP_EXEC && !rst_wake) |=> !ASLEEP)
        else $error("sleep taken outside running");

    // power-down flag stays low while asleep
    AST_PD_HOLD: assert property (@(posedge MCLK) disable iff (!RST_N)
        ASLEEP |-> !POWER_DOWN_FLAG)
        else $error("power-down flag set in sleep");

    // time-out flag stays high while asleep
    AST_TO_HOLD: assert property (@(posedge MCLK) disable iff (!RST_N)
        ASLEEP |-> TIME_OUT_FLAG)
        else $error("time-out flag low in sleep");

    // clock runs in the restart step
    AST_WAKE_CLK: assert property (@(posedge MCLK) disable iff (!RST_N)
        (r.st == swc_pkg::SWC_WAKE) |-> CORE_CLK_EN)
        else $error("clock off in restart step");

    // clock runs while the prefetched op executes
    AST_EXEC_CLK: assert property (@(posedge MCLK) disable iff (!RST_N)
        (r.st == swc_pkg::SWC_EXEC) |-> CORE_CLK_EN)
        else $error("clock off during prefetched op");

    // vector lasts one cycle
    AST_VEC_PULSE: assert property (@(posedge MCLK) disable iff (!RST_N)
        ISR_VECTOR |=> !ISR_VECTOR)
        else $error("vector longer than one cycle");

    // wake clear lasts one cycle
    AST_WDT_PULSE: assert property (@(posedge MCLK) disable iff (!RST_N)
        (WDT_CLEAR && !ASLEEP) |=> !WDT_CLEAR)
        else $error("watchdog clear longer than one cycle");

    // pins free while running
    AST_IO_RUN: assert property (@(posedge MCLK) disable iff (!RST_N)
        (r.st == swc_pkg::SWC_RUN) |-> !IO_HOLD)
        else $error("io held while running");

    // a reset wake restores clock and pins
    AST_RESET_CLK: assert property (@(posedge MCLK) disable iff (!RST_N)
        DEV_RESET |-> (CORE_CLK_EN && !IO_HOLD))
        else $error("reset left clock or pins in sleep");

endmodule // swc_sleep_wake_controller
`default_nettype wire
